// ### hw/rci_consts.vh
`ifndef RCI_CONSTS_VH
`define RCI_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RCI_OFS_CTRL    8'h00
`define RCI_OFS_IDENT   8'h04
`define RCI_OFS_TSTAMP  8'h08
`define RCI_OFS_STATUS  8'h0c
`define RCI_OFS_CMD     8'h10
`define RCI_OFS_NAME    8'h14
`define RCI_OFS_ARG     8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define RCI_CTRL_FLAG1  0
`define RCI_CTRL_FLAG2  1
`define RCI_ST_TERM     0
`define RCI_ST_TACT     1
`define RCI_ST_LIST     2
`define RCI_ST_PAUSE    3
`define RCI_ST_ZERO     4
`define RCI_ST_SPAN     5
`define RCI_ST_PEND     6
`define RCI_ST_ERR      7

// ****************************************************************
// reset values
// ****************************************************************
`define RCI_RST_CTRL    2'h0
`define RCI_RST_IDENT   16'h0000
`define RCI_RST_TSTAMP  28'h0010000

// ****************************************************************
// character codes
// ****************************************************************
`define RCI_CH_CTRL_C   8'h03
`define RCI_CH_CTRL_P   8'h10
`define RCI_CH_CTRL_T   8'h14
`define RCI_CH_BS       8'h08
`define RCI_CH_ESC      8'h1b
`define RCI_CH_CR       8'h0d
`define RCI_CH_LF       8'h0a
`define RCI_CH_SP       8'h20
`define RCI_CH_QM       8'h3f

// ****************************************************************
// reply message layout
// ****************************************************************
`define RCI_HDR_LEN     8'h11
`define RCI_HELP_LEN    8'h35

`endif

// ### hw/rci_top.v
`timescale 1ns/1ps
`include "rci_consts.vh"

// ****************************************************************
// receive byte fifo
// ****************************************************************
module rci_fifo #(
	parameter W  = 8,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire         clock_i,
	input  wire         srst_i,
	input  wire         in_valid_i,
	input  wire [W-1:0] in_data_i,
	output reg          in_ready_o,
	output wire         out_valid_o,
	output wire [W-1:0] out_data_o,
	input  wire         out_ready_i
);
	reg [W-1:0] mem [0:D-1];   // storage words
	reg [AW-1:0] wp_ff;        // write pointer
	reg [AW-1:0] rp_ff;        // read pointer
	reg [AW:0]   cnt_ff;       // words held
	wire         push;
	wire         pop;
	reg  [AW:0]  nxt_cnt;

	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_o  = mem[rp_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// count next value
	always @* begin
		nxt_cnt = cnt_ff;
		if (push & ~pop)
			nxt_cnt = cnt_ff + 1'b1;
		else if (pop & ~push)
			nxt_cnt = cnt_ff - 1'b1;
	end

	// ready is registered so the source sees full a cycle early enough
	always @(posedge clock_i) begin
		if (srst_i) begin
			wp_ff      <= {AW{1'b0}};
			rp_ff      <= {AW{1'b0}};
			cnt_ff     <= {(AW+1){1'b0}};
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				mem[wp_ff] <= in_data_i;
				wp_ff      <= (wp_ff == D-1) ? {AW{1'b0}} : wp_ff + 1'b1;
			end
			if (pop)
				rp_ff <= (rp_ff == D-1) ? {AW{1'b0}} : rp_ff + 1'b1;
			cnt_ff     <= nxt_cnt;
			in_ready_o <= (nxt_cnt < D);
		end
	end
endmodule

module rci_top #(
	parameter LINE_LEN = 32,
	parameter LINE_AW  = 5,
	parameter FIFO_D   = 4,
	parameter FIFO_AW  = 2
) (
	input  wire        clock_i,
	input  wire        srst_i,
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	input  wire        zero_in_i,
	input  wire        span_in_i,
	output reg         zero_cal_o,
	output reg         span_cal_o,
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_data_i,
	output wire        rx_ready_o,
	output reg         tx_valid_o,
	output reg  [7:0]  tx_data_o,
	input  wire        tx_ready_i
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_SCAN = 2'h1;
	localparam [1:0] S_SEND = 2'h2;
	localparam [8*53-1:0] HELP_TXT = {"C CAL\015\012D DIAG\015\012L LOGON\015\012",
		"T TEST\015\012V VAR\015\012W WARN\015\012? HELP"};

	// ****************************************************************
	// helpers
	// ****************************************************************
	// fold lower case onto upper case
	function [7:0] up;
		input [7:0] c;
		begin
			up = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
		end
	endfunction

	// decimal digit test
	function is_dig;
		input [7:0] c;
		begin
			is_dig = (c >= 8'h30 && c <= 8'h39);
		end
	endfunction

	// class index 1..6, zero when the letter is no class
	function [2:0] cls;
		input [7:0] c;
		begin
			case (c)
				8'h43:   cls = 3'h1;
				8'h44:   cls = 3'h2;
				8'h4c:   cls = 3'h3;
				8'h54:   cls = 3'h4;
				8'h56:   cls = 3'h5;
				8'h57:   cls = 3'h6;
				default: cls = 3'h0;
			endcase
		end
	endfunction

	// bcd nibble to ascii
	function [7:0] asc;
		input [3:0] d;
		begin
			asc = 8'h30 + {4'h0, d};
		end
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg  [2:0]  zs_ff;                 // zero input synchroniser
	reg  [2:0]  ss_ff;                 // span input synchroniser
	reg  [1:0]  ctrl_ff;               // configuration mode flags
	reg  [15:0] ident_ff;              // own id, four bcd digits
	reg  [27:0] tstamp_ff;             // day, hour, minute in bcd
	reg         term_ff;               // terminal mode selected
	reg  [1:0]  st_ff;                 // interpreter state
	reg  [7:0]  line_mem [0:LINE_LEN-1];
	reg  [LINE_AW:0] len_ff;           // buffered characters
	reg  [LINE_AW:0] sidx_ff;          // scan position
	reg         inw_ff;                // inside a word
	reg  [2:0]  wc_ff;                 // words seen, saturates
	reg  [7:0]  type_ff;               // type letter
	reg         isid_ff;               // second word is an id
	reg  [15:0] idacc_ff;              // id digits received
	reg  [31:0] name_ff;               // first four name chars
	reg  [2:0]  nlen_ff;               // name chars kept
	reg  [31:0] arg_ff;                // first four chars of arg one
	reg  [2:0]  alen_ff;               // arg chars kept
	reg  [3:0]  argc_ff;               // argument count
	reg         bad_ff;                // malformed line
	reg  [2:0]  cmdc_ff;               // latched class
	reg  [31:0] cmdn_ff;               // latched name
	reg  [31:0] cmda_ff;               // latched first argument
	reg  [3:0]  cmdac_ff;              // latched argument count
	reg         pend_ff;               // command waiting for software
	reg         err_ff;                // rejected line seen
	reg         help_ff;               // reply carries the listing
	reg         pause_ff;              // listing paused
	reg  [7:0]  midx_ff;               // reply byte index
	reg         ap_ff;                 // bus data phase pending
	reg         apw_ff;                // pending phase is a write
	reg  [7:0]  apa_ff;                // pending byte address
	wire        term_act;
	wire        f_valid;
	wire [7:0]  f_data;
	wire        tx_free;
	wire        take;
	wire        wr;
	reg  [7:0]  msg;
	reg  [7:0]  mlen;
	reg  [7:0]  pidx;
	reg  [31:0] rd_mux;
	reg  [7:0]  c;
	reg         start;
	reg  [2:0]  wn;
	reg         idw;
	reg         set_pend_ff;           // command accepted, one cycle pulse
	reg         set_err_ff;            // line rejected, one cycle pulse

	assign term_act = term_ff & ~ctrl_ff[`RCI_CTRL_FLAG1] & ~ctrl_ff[`RCI_CTRL_FLAG2];
	assign tx_free  = ~tx_valid_o | tx_ready_i;
	// while a plain reply goes out the fifo holds, letting it fill
	assign take     = f_valid & (((st_ff == S_IDLE) & tx_free) | ((st_ff == S_SEND) & help_ff));
	assign wr       = ap_ff & apw_ff;

	// ****************************************************************
	// receive fifo
	// ****************************************************************
	rci_fifo #(.W(8), .D(FIFO_D), .AW(FIFO_AW)) u_fifo (
		.clock_i     (clock_i),
		.srst_i      (srst_i),
		.in_valid_i  (rx_valid_i),
		.in_data_i   (rx_data_i),
		.in_ready_o  (rx_ready_o),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (take)
	);

	// ****************************************************************
	// remote calibration inputs
	// ****************************************************************
	// the isolated inputs are asynchronous; a level counts once stages two and three agree
	always @(posedge clock_i) begin
		if (srst_i) begin
			zs_ff      <= 3'h0;
			ss_ff      <= 3'h0;
			zero_cal_o <= 1'b0;
			span_cal_o <= 1'b0;
		end else begin
			zs_ff <= {zs_ff[1:0], zero_in_i};
			ss_ff <= {ss_ff[1:0], span_in_i};
			if (zs_ff[2] == zs_ff[1])
				zero_cal_o <= zs_ff[2];
			if (ss_ff[2] == ss_ff[1])
				span_cal_o <= ss_ff[2];
		end
	end

	// ****************************************************************
	// reply byte generator
	// ****************************************************************
	// header, payload, then carriage return and line feed
	always @* begin
		mlen = `RCI_HDR_LEN + (help_ff ? `RCI_HELP_LEN : 8'h02) + 8'h02;
		pidx = midx_ff - `RCI_HDR_LEN;
		case (midx_ff)
			8'h00:   msg = type_ff;
			8'h01:   msg = `RCI_CH_SP;
			8'h02:   msg = asc(tstamp_ff[27:24]);
			8'h03:   msg = asc(tstamp_ff[23:20]);
			8'h04:   msg = asc(tstamp_ff[19:16]);
			8'h05:   msg = 8'h3a;
			8'h06:   msg = asc(tstamp_ff[15:12]);
			8'h07:   msg = asc(tstamp_ff[11:8]);
			8'h08:   msg = 8'h3a;
			8'h09:   msg = asc(tstamp_ff[7:4]);
			8'h0a:   msg = asc(tstamp_ff[3:0]);
			8'h0b:   msg = `RCI_CH_SP;
			8'h0c:   msg = asc(ident_ff[15:12]);
			8'h0d:   msg = asc(ident_ff[11:8]);
			8'h0e:   msg = asc(ident_ff[7:4]);
			8'h0f:   msg = asc(ident_ff[3:0]);
			8'h10:   msg = `RCI_CH_SP;
			default: begin
				if (midx_ff == mlen - 8'h02)
					msg = `RCI_CH_CR;
				else if (midx_ff == mlen - 8'h01)
					msg = `RCI_CH_LF;
				else if (help_ff)
					msg = HELP_TXT[8*(53-1-pidx) +: 8];
				else
					msg = (pidx == 8'h00) ? 8'h4f : 8'h4b;
			end
		endcase
	end

	// ****************************************************************
	// line scanner, one buffered character per cycle
	// ****************************************************************
	always @* begin
		c     = up(line_mem[sidx_ff[LINE_AW-1:0]]);
		start = (c != `RCI_CH_SP) & ~inw_ff;
		wn    = (start && wc_ff != 3'h7) ? wc_ff + 3'h1 : wc_ff;
		idw   = (start && wn == 3'h2) ? is_dig(c) : isid_ff;
	end

	// ****************************************************************
	// interpreter state machine
	// ****************************************************************
	// the flag pulses are registered so the bus process never races this one
	always @(posedge clock_i) begin
		set_pend_ff <= 1'b0;
		set_err_ff  <= 1'b0;
		if (srst_i) begin
			st_ff      <= S_IDLE;
			term_ff    <= 1'b0;
			len_ff     <= {(LINE_AW+1){1'b0}};
			sidx_ff    <= {(LINE_AW+1){1'b0}};
			inw_ff     <= 1'b0;
			wc_ff      <= 3'h0;
			type_ff    <= 8'h00;
			isid_ff    <= 1'b0;
			idacc_ff   <= 16'h0000;
			name_ff    <= 32'h0;
			nlen_ff    <= 3'h0;
			arg_ff     <= 32'h0;
			alen_ff    <= 3'h0;
			argc_ff    <= 4'h0;
			bad_ff     <= 1'b0;
			cmdc_ff    <= 3'h0;
			cmdn_ff    <= 32'h0;
			cmda_ff    <= 32'h0;
			cmdac_ff   <= 4'h0;
			help_ff    <= 1'b0;
			pause_ff   <= 1'b0;
			midx_ff    <= 8'h00;
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
		end else begin
			if (tx_ready_i)
				tx_valid_o <= 1'b0;
			case (st_ff)
				S_IDLE: begin
					if (take) begin
						// echo everything but the mode switches in terminal mode
						if (term_act && f_data != `RCI_CH_CTRL_T && f_data != `RCI_CH_CTRL_C) begin
							tx_valid_o <= 1'b1;
							tx_data_o  <= f_data;
						end
						if (f_data == `RCI_CH_CTRL_T)
							term_ff <= 1'b1;
						else if (f_data == `RCI_CH_CTRL_C)
							term_ff <= 1'b0;
						else if (f_data == `RCI_CH_CR) begin
							st_ff   <= S_SCAN;
							sidx_ff <= {(LINE_AW+1){1'b0}};
							inw_ff  <= 1'b0;
							wc_ff   <= 3'h0;
							isid_ff <= 1'b0;
							idacc_ff <= 16'h0000;
							nlen_ff <= 3'h0;
							name_ff <= 32'h0;
							alen_ff <= 3'h0;
							arg_ff  <= 32'h0;
							argc_ff <= 4'h0;
							bad_ff  <= 1'b0;
							type_ff <= 8'h00;
						end else if (term_act && f_data == `RCI_CH_BS) begin
							if (len_ff != {(LINE_AW+1){1'b0}})
								len_ff <= len_ff - 1'b1;
						end else if (term_act && f_data == `RCI_CH_ESC)
							len_ff <= {(LINE_AW+1){1'b0}};
						else if (len_ff < LINE_LEN) begin
							// characters past the buffer end are dropped
							line_mem[len_ff[LINE_AW-1:0]] <= f_data;
							len_ff <= len_ff + 1'b1;
						end
					end
				end
				S_SCAN: begin
					if (sidx_ff < len_ff) begin
						sidx_ff <= sidx_ff + 1'b1;
						if (c == `RCI_CH_SP)
							inw_ff <= 1'b0;
						else begin
							inw_ff <= 1'b1;
							wc_ff  <= wn;
							if (wn == 3'h1) begin
								if (start)
									type_ff <= c;
								else
									bad_ff <= 1'b1;
							end else if (wn == 3'h2 && idw) begin
								isid_ff <= 1'b1;
								if (is_dig(c))
									idacc_ff <= {idacc_ff[11:0], c[3:0]};
								else
									bad_ff <= 1'b1;
							end else if ((wn == 3'h2) || (wn == 3'h3 && isid_ff)) begin
								if (nlen_ff != 3'h4) begin
									name_ff <= {name_ff[23:0], c};
									nlen_ff <= nlen_ff + 3'h1;
								end
							end else begin
								if (start && argc_ff != 4'hf)
									argc_ff <= argc_ff + 4'h1;
								if ((wn == (isid_ff ? 3'h4 : 3'h3)) && alen_ff != 3'h4) begin
									arg_ff  <= {arg_ff[23:0], c};
									alen_ff <= alen_ff + 3'h1;
								end
							end
						end
					end else begin
						len_ff   <= {(LINE_AW+1){1'b0}};
						midx_ff  <= 8'h00;
						pause_ff <= 1'b0;
						help_ff  <= (type_ff == `RCI_CH_QM);
						if (isid_ff && idacc_ff != ident_ff)
							st_ff <= S_IDLE;
						else if (type_ff == `RCI_CH_QM && !bad_ff && (wc_ff == 3'h1 ||
								(wc_ff == 3'h2 && isid_ff)))
							st_ff <= S_SEND;
						else if (cls(type_ff) != 3'h0 && nlen_ff != 3'h0 && !bad_ff) begin
							cmdc_ff  <= cls(type_ff);
							cmdn_ff  <= name_ff;
							cmda_ff  <= arg_ff;
							cmdac_ff <= argc_ff;
							set_pend_ff <= 1'b1;
							st_ff    <= S_SEND;
						end else begin
							// an empty line is no error
							set_err_ff <= (wc_ff != 3'h0);
							st_ff   <= S_IDLE;
						end
					end
				end
				S_SEND: begin
					if (take) begin
						if (f_data == `RCI_CH_CTRL_C)
							pause_ff <= 1'b1;
						else if (f_data == `RCI_CH_CTRL_P)
							pause_ff <= 1'b0;
					end
					if (tx_free && !pause_ff) begin
						tx_valid_o <= 1'b1;
						tx_data_o  <= msg;
						midx_ff    <= midx_ff + 8'h01;
						if (midx_ff == mlen - 8'h01) begin
							st_ff    <= S_IDLE;
							pause_ff <= 1'b0;
						end
					end
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	// read data is muxed from the address phase and registered for the data phase
	always @* begin
		case (haddr_i[7:0])
			`RCI_OFS_CTRL:   rd_mux = {30'h0, ctrl_ff};
			`RCI_OFS_IDENT:  rd_mux = {16'h0, ident_ff};
			`RCI_OFS_TSTAMP: rd_mux = {4'h0, tstamp_ff};
			`RCI_OFS_STATUS: rd_mux = {24'h0, err_ff, pend_ff, span_cal_o, zero_cal_o,
				pause_ff, (st_ff == S_SEND) & help_ff, term_act, term_ff};
			`RCI_OFS_CMD:    rd_mux = {24'h0, cmdac_ff, 1'b0, cmdc_ff};
			`RCI_OFS_NAME:   rd_mux = cmdn_ff;
			`RCI_OFS_ARG:    rd_mux = cmda_ff;
			default:         rd_mux = 32'h0;
		endcase
		if (|haddr_i[31:8])
			rd_mux = 32'h0;
	end

	always @(posedge clock_i) begin
		if (srst_i) begin
			ap_ff       <= 1'b0;
			apw_ff      <= 1'b0;
			apa_ff      <= 8'h00;
			hrdata_o    <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			ctrl_ff     <= `RCI_RST_CTRL;
			ident_ff    <= `RCI_RST_IDENT;
			tstamp_ff   <= `RCI_RST_TSTAMP;
			pend_ff     <= 1'b0;
			err_ff      <= 1'b0;
		end else begin
			ap_ff  <= hsel_i & htrans_i[1] & hready_i;
			apw_ff <= hwrite_i;
			apa_ff <= (|haddr_i[31:8]) ? 8'hff : haddr_i[7:0];
			if (hsel_i & htrans_i[1] & hready_i & ~hwrite_i)
				hrdata_o <= rd_mux;
			if (wr && apa_ff == `RCI_OFS_CTRL)
				ctrl_ff <= hwdata_i[1:0];
			if (wr && apa_ff == `RCI_OFS_IDENT)
				ident_ff <= hwdata_i[15:0];
			if (wr && apa_ff == `RCI_OFS_TSTAMP)
				tstamp_ff <= hwdata_i[27:0];
			// sticky flags: write one clears, a new event in the same cycle wins
			pend_ff <= set_pend_ff | (pend_ff & ~(wr && apa_ff == `RCI_OFS_STATUS &&
				hwdata_i[`RCI_ST_PEND]));
			err_ff  <= set_err_ff | (err_ff & ~(wr && apa_ff == `RCI_OFS_STATUS &&
				hwdata_i[`RCI_ST_ERR]));
		end
	end
endmodule

// ### test/rci_host.sv
`timescale 1ns/1ps
// ********************************
// serial host stand-in
// ********************************
module rci_host (
	input  wire       clock_i,
	input  wire       srst_i,
	input  wire       slow_i,
	input  wire       rx_ready_i,
	output reg        rx_valid_o = 1'b0,
	output reg  [7:0] rx_data_o = 8'h00,
	input  wire       tx_valid_i,
	input  wire [7:0] tx_data_i,
	output reg        tx_ready_o = 1'b0
);
	logic [7:0] sq[$];            // bytes still to send
	logic [7:0] rq[$];            // bytes seen from the device
	reg   [1:0] stall_ff = 2'h0;  // sink stall phase
	// queue a line; callers end each command with a return
	task send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			sq.push_back(s[i]);
		end
	endtask
	// one byte offered at a time and held until taken
	always @(posedge clock_i) begin
		if (rx_valid_o && rx_ready_i) begin
			void'(sq.pop_front());
		end
		if (srst_i || sq.size() == 0) begin
			rx_valid_o <= 1'b0;
			// idle data keeps changing so stale bytes cannot pass as valid
			rx_data_o  <= ~rx_data_o;
		end else begin
			rx_valid_o <= 1'b1;
			rx_data_o  <= sq[0];
		end
	end
	// sink takes every byte, or one cycle in four when slow
	always @(posedge clock_i) begin
		stall_ff   <= stall_ff + 2'h1;
		tx_ready_o <= !slow_i || stall_ff == 2'h3;
		if (tx_valid_i && tx_ready_o) begin
			rq.push_back(tx_data_i);
		end
	end
endmodule

// ### test/rci_top_asserts.sv
`timescale 1ns/1ps
// ********************************
// port level checker
// ********************************
module rci_chk (
	input wire        clock_i,
	input wire        srst_i,
	input wire        hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire        hready_i,
	input wire [31:0] hrdata_o,
	input wire        zero_in_i,
	input wire        span_in_i,
	input wire        zero_cal_o,
	input wire        span_cal_o,
	input wire        tx_valid_o,
	input wire [7:0]  tx_data_o,
	input wire        tx_ready_i
);
	reg [7:0] last_tx_ff; // byte that left before the current one
	// remember each transmitted byte; a line feed must follow a return
	always @(posedge clock_i) begin
		if (tx_valid_o && tx_ready_i) begin
			last_tx_ff <= tx_data_o;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// a byte offered but not yet taken
	sequence tx_stall_s;
		tx_valid_o && !tx_ready_i;
	endsequence
	// address phase of a read of the decoded command
	sequence cmd_rd_s;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i == 32'h10;
	endsequence
	// six cycles leave room for the three stage synchroniser and output flop
	zero_on_a: assert property (zero_in_i [*6] |-> zero_cal_o)
		else $error("zero mode not entered");
	zero_off_a: assert property (!zero_in_i [*6] |-> !zero_cal_o)
		else $error("zero mode not left");
	span_on_a: assert property (span_in_i [*6] |-> span_cal_o)
		else $error("span mode not entered");
	span_off_a: assert property (!span_in_i [*6] |-> !span_cal_o)
		else $error("span mode not left");
	reset_idle_a: assert property ($fell(srst_i) |-> hrdata_o == 32'h0 && !tx_valid_o)
		else $error("outputs not idle after reset");
	tx_hold_a: assert property (tx_stall_s |=> tx_valid_o && $stable(tx_data_o))
		else $error("refused byte not held");
	crlf_end_a: assert property (tx_valid_o && tx_ready_i && tx_data_o == 8'h0a
		|-> last_tx_ff == 8'h0d) else $error("line feed without return");
	cmd_class_a: assert property (cmd_rd_s |=> hrdata_o[2:0] <= 3'h6
		&& hrdata_o[31:8] == 24'h0) else $error("command class out of range");
endmodule
bind rci_top rci_chk chk_u (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hready_i, .hrdata_o, .zero_in_i, .span_in_i, .zero_cal_o, .span_cal_o, .tx_valid_o,
	.tx_data_o, .tx_ready_i);

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// ********************************
	// stimulus and wiring
	// ********************************
	logic        clock_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0]  htrans_i = 2'h0;
	logic        hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic        zero_in_i = 1'b0;
	logic        span_in_i = 1'b0;
	logic        slow_i = 1'b0;
	wire  [31:0] hrdata_o;
	wire         hreadyout_o, hresp_o, zero_cal_o, span_cal_o;
	wire         rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
	wire  [7:0]  rx_data_i, tx_data_o;
	logic [31:0] rd_v;          // last read word
	int          n_errors = 0;  // mismatches
	int          checks = 0;    // comparisons made
	int          cyc = 0;       // cycles run
	always #4 clock_i = ~clock_i;
	rci_top dut_u (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .zero_in_i,
		.span_in_i, .zero_cal_o, .span_cal_o, .rx_valid_i, .rx_data_i, .rx_ready_o,
		.tx_valid_o, .tx_data_o, .tx_ready_i);
	rci_host host_u (.clock_i, .srst_i, .slow_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_ready_o(tx_ready_i));
	// ********************************
	// tasks
	// ********************************
	task complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// single word transfer, entered just after a rising edge
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel_i   <= 1'b1;
		haddr_i  <= a;
		hwrite_i <= w;
		htrans_i <= 2'h2;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1) @(posedge clock_i);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1) @(posedge clock_i);
		rd_v = hrdata_o;
	endtask
	task rchk(input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask
	// done once nothing is queued and the transmitter stayed quiet a while
	task settle;
		int q;
		q = 0;
		while (q < 40) begin
			@(posedge clock_i);
			q = (host_u.sq.size() == 0 && tx_valid_o === 1'b0) ? q + 1 : 0;
		end
	endtask
	task line(input string s);
		host_u.rq.delete();
		host_u.send_str(s);
		settle();
	endtask
	// byte count of what came back, and its last bytes
	task tail(input string t, input int n);
		chk(host_u.rq.size(), n);
		if (host_u.rq.size() >= t.len()) begin
			for (int i = 0; i < t.len(); i++) begin
				chk(host_u.rq[host_u.rq.size() - t.len() + i], t[i]);
			end
		end
	endtask
	// hang guard: far above the few thousand cycles the run needs
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			$display("CHECK FAILED t=%0t no progress", $time);
			complete_run();
		end
	end
	// ********************************
	// main sequence
	// ********************************
	initial begin
		int n;
		string s;
		s = "CDLTVW";
		repeat (10) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		rchk(32'h00, 32'h0);
		chk({hreadyout_o, hresp_o}, 2'h2);
		rchk(32'h08, 32'h0010000);
		rchk(32'h0c, 32'h0);
		ahb(1'b1, 32'h1c, 32'hffffffff);
		rchk(32'h1c, 32'h0);
		ahb(1'b1, 32'h04, 32'h0200);
		// contact inputs
		zero_in_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(zero_cal_o, 1'b1);
		rchk(32'h0c, 32'h10);
		zero_in_i <= 1'b0;
		span_in_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(zero_cal_o, 1'b0);
		chk(span_cal_o, 1'b1);
		span_in_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		// computer mode: lower case command, own id, no echo
		line("c 0200 nm ab\015");
		tail(" 001:00:00 0200 OK\015\012", 21);
		rchk(32'h10, 32'h11);
		rchk(32'h14, 32'h4e4d);
		rchk(32'h18, 32'h4142);
		rchk(32'h0c, 32'h40);
		ahb(1'b1, 32'h0c, 32'hc0);
		line("d nm");
		rchk(32'h0c, 32'h0);
		line("\015");
		rchk(32'h0c, 32'h40);
		ahb(1'b1, 32'h0c, 32'hc0);
		line("w 0300 nm\015");
		chk(host_u.rq.size(), 0);
		rchk(32'h0c, 32'h0);
		for (int i = 0; i < 6; i++) begin
			line({s.substr(i, i), " nm\015"});
			rchk(32'h10, i + 1);
		end
		ahb(1'b1, 32'h0c, 32'hc0);
		line("q nm\015");
		rchk(32'h0c, 32'h80);
		ahb(1'b1, 32'h0c, 32'hc0);
		// either flag keeps the terminal inactive
		for (int f = 1; f < 3; f++) begin
			ahb(1'b1, 32'h00, f);
			line("\024");
			ahb(1'b0, 32'h0c, 32'h0);
			chk(rd_v[1], 1'b0);
		end
		ahb(1'b1, 32'h00, 32'h0);
		rchk(32'h0c, 32'h3);
		// echo, escape and backspace
		line("x\033");
		tail("x\033", 2);
		line("d nq\010m\015");
		tail(" 001:00:00 0200 OK\015\012", 28);
		rchk(32'h10, 32'h2);
		rchk(32'h14, 32'h4e4d);
		// help listing against a slow sink, paused and resumed
		slow_i <= 1'b1;
		line("");
		host_u.send_str("?\015");
		rd_v = 32'h0;
		for (int k = 0; k < 200 && rd_v[2] !== 1'b1; k++) ahb(1'b0, 32'h0c, 32'h0);
		host_u.send_str("\003");
		repeat (60) @(posedge clock_i);
		n = host_u.rq.size();
		rchk(32'h0c, 32'h4f);
		repeat (60) @(posedge clock_i);
		chk(host_u.rq.size(), n);
		host_u.send_str("\020");
		settle();
		tail("W WARN\015\012? HELP\015\012", 74);
		slow_i <= 1'b0;
		// control-C outside a listing: computer mode, no echo
		line("\003a");
		chk(host_u.rq.size(), 0);
		ahb(1'b0, 32'h0c, 32'h0);
		chk(rd_v[1:0], 2'h0);
		complete_run();
	end
endmodule
